// ---- uhsp_defs.vh ----
// constants for the uart host serial port
`ifndef UHSP_DEFS_VH
`define UHSP_DEFS_VH
`define UHSP_ADDR_PREFIX 4'h6
`define UHSP_DIR_BIT 0
`define UHSP_SUB_REG_HI 5
`define UHSP_SUB_REG_LO 3
`define UHSP_SUB_CH_HI 2
`define UHSP_SUB_CH_LO 1
`define UHSP_SPI_DIR_BIT 7
`define UHSP_CH_VALID 2'h0
`define UHSP_BURST_MAX 8'h80
`define UHSP_STRAP_VCC 2'h0
`define UHSP_STRAP_GND 2'h1
`define UHSP_STRAP_SCL 2'h2
`define UHSP_STRAP_SDA 2'h3
`define UHSP_CLK_MHZ 25
`define UHSP_I2C_STD_KBPS 100
`define UHSP_I2C_FAST_KBPS 400
`define UHSP_SPI_MAX_KBPS 26000
`endif

// ---- uhsp_sync.v ----
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module uhsp_sync #(
  parameter W = 4
) (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // asynchronous levels in, synchronised levels out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q; // first stage, read only by the second

  // two stage capture
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{1'b1}};
      sync_out <= {W{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // uhsp_sync

// ---- uhsp_port.v ----
// host serial port: i2c or spi slave access to uart registers
`timescale 1ns/1ps
`include "uhsp_defs.vh"
module uhsp_port (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // interface select strap, high selects i2c
  input wire i2c_sel,
  // address straps, already resolved to connection codes
  input wire [1:0] addr_strap_high,
  input wire [1:0] addr_strap_low,
  // serial pins: scl doubles as spi clock
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire cs_n,
  input wire si,
  output reg so,
  // register side toward the uart core
  output reg reg_wr,
  output reg reg_rd,
  output reg [2:0] reg_idx,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire tx_full,
  // status
  output reg busy,
  output reg [7:0] burst_cnt
);
  // phases of a transfer
  localparam PH_IDLE = 3'h0;
  localparam PH_ADDR = 3'h1;
  localparam PH_SUB = 3'h2;
  localparam PH_WDATA = 3'h3;
  localparam PH_RDATA = 3'h4;
  localparam PH_SKIP = 3'h5;

  wire scl_s; // synchronised pins
  wire sda_s;
  wire cs_n_s;
  wire si_s;
  wire [4:0] strap_s; // mode strap, then high and low address straps
  reg scl_p_q; // previous samples for edge finding
  reg sda_p_q;
  reg [2:0] ph_q;
  reg [7:0] sh_q; // shift register, msb first
  reg [2:0] bit_q; // bit count within a byte
  reg ack_q; // in i2c ack slot
  reg rdir_q; // read transaction
  reg mack_q; // ack slot belongs to the master on a read
  reg full_q; // eighth bit of a byte has been clocked in
  reg [7:0] tx_q; // byte being shifted out
  reg [7:0] my_addr_q;

  uhsp_sync #(.W(9)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({i2c_sel, addr_strap_high, addr_strap_low,
      scl_in, sda_in, cs_n, si}),
    .sync_out({strap_s, scl_s, sda_s, cs_n_s, si_s})
  );

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire i2c_start = strap_s[4] & scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire i2c_stop = strap_s[4] & scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire [7:0] byte_in = {sh_q[6:0], strap_s[4] ? sda_s : si_s};

  // strap encoding: vcc/scl give 0 on high strap, gnd/sda give 1
  function [2:0] strap_bits;
    input [1:0] hi;
    input [1:0] lo;
    begin
      strap_bits = {(hi == `UHSP_STRAP_GND) | (hi == `UHSP_STRAP_SDA),
                    lo};
    end
  endfunction

  // channel check on a command or sub-address byte
  function ch_ok;
    input [7:0] b;
    begin
      ch_ok = (b[`UHSP_SUB_CH_HI:`UHSP_SUB_CH_LO] == `UHSP_CH_VALID);
    end
  endfunction

  // main sequencer, driven by sampled bus edges
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ph_q <= PH_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      ack_q <= 1'b0;
      rdir_q <= 1'b0;
      mack_q <= 1'b0;
      full_q <= 1'b0;
      tx_q <= 8'h00;
      my_addr_q <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      so <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_idx <= 3'h0;
      reg_wdata <= 8'h00;
      busy <= 1'b0;
      burst_cnt <= 8'h00;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      // own address follows the straps continuously
      my_addr_q <= {`UHSP_ADDR_PREFIX,
        strap_bits(strap_s[3:2], strap_s[1:0]), 1'b0};
      if (strap_s[4]) begin
        // i2c slave
        so <= 1'b0;
        if (i2c_start) begin
          ph_q <= PH_ADDR;
          bit_q <= 3'h0;
          ack_q <= 1'b0;
          full_q <= 1'b0;
          mack_q <= 1'b0;
          sda_oe <= 1'b0;
          busy <= 1'b1;
          burst_cnt <= 8'h00;
        end else if (i2c_stop) begin
          ph_q <= PH_IDLE;
          sda_oe <= 1'b0;
          busy <= 1'b0;
        end else if (ph_q != PH_IDLE && ph_q != PH_SKIP) begin
          if (scl_rise && !ack_q) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            full_q <= (bit_q == 3'h7); // fall after start is no byte end
          end
          if (scl_fall) begin
            if (ack_q) begin
              // end of ack slot: release or drive next read bit
              ack_q <= 1'b0;
              mack_q <= 1'b0;
              if (ph_q == PH_RDATA) begin
                sda_out <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                sda_oe <= ~tx_q[7];
              end else begin
                sda_oe <= 1'b0;
              end
            end else if (full_q) begin
              // a full byte ended: decide the ack slot
              ack_q <= 1'b1;
              case (ph_q)
                PH_ADDR: begin
                  if (sh_q[7:1] == my_addr_q[7:1]) begin
                    rdir_q <= sh_q[`UHSP_DIR_BIT];
                    sda_out <= 1'b0;
                    sda_oe <= 1'b1;
                    if (sh_q[`UHSP_DIR_BIT]) begin
                      ph_q <= PH_RDATA;
                      reg_rd <= 1'b1;
                      tx_q <= reg_rdata;
                    end else begin
                      ph_q <= PH_SUB;
                    end
                  end else begin
                    ph_q <= PH_SKIP;
                    sda_oe <= 1'b0;
                  end
                end
                PH_SUB: begin
                  reg_idx <= sh_q[`UHSP_SUB_REG_HI:`UHSP_SUB_REG_LO];
                  sda_oe <= ch_ok(sh_q);
                  ph_q <= ch_ok(sh_q) ? PH_WDATA : PH_SKIP;
                end
                PH_WDATA: begin
                  sda_oe <= ~tx_full;
                  if (!tx_full) begin
                    reg_wr <= 1'b1;
                    reg_wdata <= sh_q;
                    burst_cnt <= burst_cnt + 8'h01;
                  end
                end
                PH_RDATA: begin
                  mack_q <= 1'b1; // master answers this slot
                  sda_oe <= 1'b0;
                end
                default: begin
                  sda_oe <= 1'b0;
                end
              endcase
            end else if (ph_q == PH_RDATA) begin
              // shift next read bit, open drain
              sda_out <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[7];
            end
          end
          // master ack on read: sample in slot, stop if nack
          if (scl_rise && mack_q && ph_q == PH_RDATA) begin
            sda_oe <= 1'b0;
            if (sda_s) begin
              ph_q <= PH_SKIP;
            end else begin
              reg_rd <= 1'b1;
              tx_q <= reg_rdata;
            end
          end
        end
      end else begin
        // spi slave
        sda_oe <= 1'b0;
        if (cs_n_s) begin
          ph_q <= PH_IDLE;
          bit_q <= 3'h0;
          busy <= 1'b0;
          so <= 1'b0;
        end else begin
          if (ph_q == PH_IDLE) begin
            ph_q <= PH_SUB;
            busy <= 1'b1;
            burst_cnt <= 8'h00;
          end
          if (scl_rise) begin
            sh_q <= byte_in;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              case (ph_q)
                PH_IDLE, PH_SUB: begin
                  reg_idx <= byte_in[`UHSP_SUB_REG_HI:`UHSP_SUB_REG_LO];
                  rdir_q <= byte_in[`UHSP_SPI_DIR_BIT];
                  if (!ch_ok(byte_in)) begin
                    ph_q <= PH_SKIP;
                  end else if (byte_in[`UHSP_SPI_DIR_BIT]) begin
                    ph_q <= PH_RDATA;
                    reg_rd <= 1'b1;
                    tx_q <= reg_rdata;
                  end else begin
                    ph_q <= PH_WDATA;
                  end
                end
                PH_WDATA: begin
                  if (burst_cnt < `UHSP_BURST_MAX && !tx_full) begin
                    reg_wr <= 1'b1;
                    reg_wdata <= byte_in;
                    burst_cnt <= burst_cnt + 8'h01;
                  end
                end
                PH_RDATA: begin
                  if (burst_cnt < `UHSP_BURST_MAX - 8'h01) begin
                    reg_rd <= 1'b1;
                    tx_q <= reg_rdata;
                    burst_cnt <= burst_cnt + 8'h01;
                  end else begin
                    tx_q <= 8'h00;
                  end
                end
                default: begin
                  ph_q <= PH_SKIP;
                end
              endcase
            end
          end
          if (scl_fall && ph_q == PH_RDATA) begin
            so <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule // uhsp_port

// ---- uhsp_port_properties.sv ----
// pin level assertions for the host serial port
`timescale 1ns/1ps
module uhsp_port_properties (
  // clock and reset
  input wire core_clk,
  input wire reset_n,
  // pins and register side
  input wire i2c_sel,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire so,
  input wire reg_wr,
  input wire tx_full,
  input wire busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // start and stop as seen on the raw lines
  sequence s_start;
    $fell(sda_in) && scl_in && i2c_sel;
  endsequence
  sequence s_stop;
    $rose(sda_in) && scl_in && i2c_sel;
  endsequence
  a_start_busy: assert property (s_start |-> ##[1:6] busy)
    else $error("no busy after start");
  a_stop_idle: assert property (s_stop |-> ##[1:6] !busy)
    else $error("busy after stop");
  a_ack_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_ack_edge: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda taken while scl high");
  a_full_nack: assert property (tx_full && $past(tx_full) |-> !reg_wr)
    else $error("write while fifo full");
  a_wr_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  a_spi_no_sda: assert property (!i2c_sel |-> !sda_oe)
    else $error("sda driven in spi mode");
  a_so_fall: assert property (!i2c_sel && $changed(so) |-> !scl_in)
    else $error("so moved while clock high");
endmodule // uhsp_port_properties
bind uhsp_port uhsp_port_properties chk (.*);

// ---- uhsp_host_model.sv ----
// serial master model driving the host port pins
`timescale 1ns/1ps
module uhsp_host_model (
  // clock
  input wire core_clk,
  // bus lines, sda pulled down by sda_low
  output reg scl,
  output reg sda_low,
  input wire sda,
  output reg cs_n,
  output reg si,
  input wire so
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // quarter of a 320 ns link period
  task q;
    repeat (2) @(posedge core_clk);
  endtask
  // start: sda falls while scl high
  task i2c_start;
    begin
      sda_low <= 1'b1;
      q;
      scl <= 1'b0;
      q;
    end
  endtask
  // stop: sda rises while scl high, scl left high
  task i2c_stop;
    begin
      sda_low <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b0;
      q;
      q;
    end
  endtask
  // eight bits msb first then ninth bit; a 1 releases sda
  task i2c_byte(input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low <= ~tx[i];
        q;
        scl <= 1'b1;
        q;
        rx[i] = sda;
        q;
        scl <= 1'b0;
        q;
      end
    end
  endtask
  // spi byte: si set in low phase, so sampled in the middle of the high phase
  task spi_byte(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si <= tx[i];
        q;
        scl <= 1'b1;
        q;
        rx[i] = so;
        q;
        scl <= 1'b0;
        q;
      end
    end
  endtask
  // chip select with scl idle low; si shows a changed level
  task spi_cs(input v);
    begin
      cs_n <= v;
      si <= ~si;
      q;
      q;
    end
  endtask
endmodule // uhsp_host_model

// ---- uhsp_port_tb.sv ----
// self-checking bench for the host serial port
`timescale 1ns/1ps
module uhsp_port_tb;
  // design inputs
  reg core_clk = 1'b0;
  reg reset_n;
  reg i2c_sel;
  reg [1:0] s_hi;
  reg [1:0] s_lo;
  reg [7:0] rdata;
  reg tx_full;
  // outputs and bus lines
  wire sda_out, sda_oe, so, reg_wr, reg_rd, busy, scl, sda_low, cs_n, si;
  wire [2:0] reg_idx;
  wire [7:0] reg_wdata, burst_cnt;
  // open drain sda, high unless pulled
  wire sda_in = ~(sda_low | (sda_oe & ~sda_out));
  integer n_errors = 0;
  integer checked = 0;
  integer n_wr = 0;
  integer n_rd = 0;
  integer i;
  reg [10:0] w_last = 11'h000;
  reg [8:0] rx;
  reg [7:0] b;
  always #20 core_clk = ~core_clk;
  uhsp_port dut (.core_clk(core_clk), .reset_n(reset_n), .i2c_sel(i2c_sel),
    .addr_strap_high(s_hi), .addr_strap_low(s_lo), .scl_in(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cs_n(cs_n),
    .si(si), .so(so), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .tx_full(tx_full),
    .busy(busy), .burst_cnt(burst_cnt));
  uhsp_host_model host (.core_clk(core_clk), .scl(scl), .sda_low(sda_low),
    .sda(sda_in), .cs_n(cs_n), .si(si), .so(so));
  // log every register write
  always @(posedge core_clk) begin
    if (reg_wr === 1'b1) begin
      n_wr = n_wr + 1;
      w_last = {reg_idx, reg_wdata};
    end
    if (reg_rd === 1'b1)
      n_rd = n_rd + 1;
  end
  task cmp(input [23:0] got, input [23:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // reset for 20 cycles in the chosen mode, scl at its idle level
  task do_reset(input sel);
    begin
      reset_n <= 1'b0;
      i2c_sel <= sel;
      s_hi <= 2'h0;
      s_lo <= 2'h0;
      rdata <= 8'h00;
      tx_full <= 1'b0;
      host.scl <= sel;
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // bounded wait for idle; running out ends the run
  task wait_idle;
    begin
      for (i = 0; i < 20 && busy !== 1'b0; i = i + 1)
        @(posedge core_clk);
      cmp(busy, 1'b0);
      if (busy !== 1'b0) end_sim;
    end
  endtask
  // one address byte, ninth bit returned in rx, then stop
  task addr_try(input [7:0] a);
    begin
      host.i2c_start;
      host.i2c_byte({a, 1'b1}, rx);
      host.i2c_stop;
      wait_idle;
    end
  endtask
  // every strap pair: own address acked, neighbour refused
  task t_addr;
    integer h, l;
    begin
      for (h = 0; h < 4; h = h + 1)
        for (l = 0; l < 4; l = l + 1) begin
          s_hi <= h[1:0];
          s_lo <= l[1:0];
          b = {4'h6, h[0], l[1:0], 1'b0};
          @(posedge core_clk);
          addr_try(b);
          cmp(rx[0], 1'b0);
          addr_try(b ^ 8'h04);
          cmp(rx[0], 1'b1);
        end
    end
  endtask
  // write, refusal on full fifo, then read (straps left at 0x6e)
  task t_i2c;
    begin
      host.i2c_start;
      host.i2c_byte({8'h6e, 1'b1}, rx);
      host.i2c_byte({8'h28, 1'b1}, rx);
      host.i2c_byte({8'ha5, 1'b1}, rx);
      cmp(rx[0], 1'b0);
      tx_full <= 1'b1;
      host.i2c_byte({8'h5a, 1'b1}, rx);
      cmp(rx[0], 1'b1);
      host.i2c_stop;
      wait_idle;
      cmp({n_wr[4:0], w_last}, {5'h1, 3'h5, 8'ha5});
      rdata <= 8'h3c;
      tx_full <= 1'b0;
      host.i2c_start;
      host.i2c_byte({8'h6f, 1'b1}, rx);
      cmp(rx[0], 1'b0);
      host.i2c_byte(9'h1ff, rx);
      cmp(rx[8:1], 8'h3c);
      host.i2c_stop;
      wait_idle;
      cmp(n_rd[7:0], 8'h01);
    end
  endtask
  // spi: burst past the 128 byte burst limit, reserved channel, then a read
  task t_spi;
    integer j;
    begin
      do_reset(1'b0);
      n_wr = 0;
      host.spi_cs(1'b0);
      host.spi_byte(8'h28, b);
      for (j = 0; j < 129; j = j + 1)
        host.spi_byte(j[7:0], b);
      host.spi_cs(1'b1);
      wait_idle;
      cmp({n_wr[7:0], w_last}, {8'h80, 3'h5, 8'h7f});
      cmp(burst_cnt, 8'h80);
      host.spi_cs(1'b0);
      host.spi_byte(8'h2a, b);
      host.spi_byte(8'h99, b);
      host.spi_cs(1'b1);
      wait_idle;
      cmp(n_wr[7:0], 8'h80);
      rdata <= 8'hc3;
      host.spi_cs(1'b0);
      host.spi_byte(8'ha8, b);
      host.spi_byte(8'h00, b);
      host.spi_cs(1'b1);
      wait_idle;
      cmp(b, 8'hc3);
    end
  endtask
  initial begin
    do_reset(1'b1);
    t_addr;
    t_i2c;
    t_spi;
    end_sim;
  end
  // watchdog on the whole run
  initial begin
    #3000000;
    n_errors = n_errors + 1;
    end_sim;
  end
endmodule // uhsp_port_tb
